// file: hw/epi_pkg.sv
package epi_pkg;

  // Register offsets (byte addresses, one word each).
  localparam logic [3:0] EPI_OFS_PIN_A_CTRL  = 4'h0;
  localparam logic [3:0] EPI_OFS_PIN_B_CTRL  = 4'h4;
  localparam logic [3:0] EPI_OFS_IRQ_EN_ONE  = 4'h8;
  localparam logic [3:0] EPI_OFS_STATUS      = 4'hC;
  localparam int         EPI_ADDR_W          = 4;

  // Pin control register fields.
  localparam int EPI_CTL_INPUT_EN = 3;
  localparam int EPI_CTL_POLARITY = 2;
  localparam int EPI_CTL_BOTH     = 1;
  localparam int EPI_CTL_SYNC_SEL = 0;
  localparam logic [3:0] EPI_CTL_RESET    = 4'h0;
  localparam logic [3:0] EPI_IRQ_EN_RESET = 4'h0;

  // Enable register fields.
  localparam int EPI_EN_EXT_A = 0;
  localparam int EPI_EN_EXT_B = 1;

  // Status register fields.
  localparam int EPI_ST_FLAG_A     = 0;
  localparam int EPI_ST_FLAG_B     = 1;
  localparam int EPI_ST_POWER_DOWN = 2;
  localparam int EPI_ST_WAKE_A     = 3;
  localparam int EPI_ST_WAKE_B     = 4;

  // Command codes presented by the instruction side, one per cycle.
  localparam logic [2:0] EPI_CMD_NONE      = 3'h0;
  localparam logic [2:0] EPI_CMD_SKIP_A    = 3'h1;
  localparam logic [2:0] EPI_CMD_SKIP_B    = 3'h2;
  localparam logic [2:0] EPI_CMD_ARM       = 3'h3;
  localparam logic [2:0] EPI_CMD_PD        = 3'h4;
  localparam logic [2:0] EPI_CMD_PD_KEEP   = 3'h5;
  localparam logic [2:0] EPI_CMD_WAKE_EN_A = 3'h6;
  localparam logic [2:0] EPI_CMD_WAKE_EN_B = 3'h7;

  typedef enum logic [2:0] {
    EPI_RUN   = 3'b001,
    EPI_ARMED = 3'b010,
    EPI_DOWN  = 3'b100
  } epi_pwr_e;

  typedef struct packed {
    logic [2:0] cmd;
    logic       wdata;
  } epi_cmd_s;

  typedef struct packed {
    logic                  read;
    logic                  write;
    logic [EPI_ADDR_W-1:0] address;
    logic [31:0]           writedata;
  } epi_bus_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } epi_bus_rsp_s;

endpackage : epi_pkg

// file: hw/epi_detect.sv
`timescale 1ns/1ps
// Edge/level detector for one external pin, with synchroniser.
module epi_detect (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       pin,
  input  wire logic [3:0] ctrl,
  output logic            hit,
  output logic            level_ok
);
  import epi_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic gated;
    logic hit;
    logic level_ok;
  } epi_det_s;

  epi_det_s st;
  epi_det_s next_st;

  // The gated level is what the edge logic sees, so toggling enable or polarity can look
  // like an edge; that spurious set is the documented behaviour, not a bug.
  always_comb begin
    logic lvl;
    lvl = 1'b0;
    next_st    = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    lvl = ctrl[EPI_CTL_INPUT_EN] & (st.s2 ~^ ctrl[EPI_CTL_POLARITY]);
    next_st.gated    = lvl;
    next_st.level_ok = lvl;
    if (ctrl[EPI_CTL_BOTH]) begin
      next_st.hit = lvl ^ st.gated;
    end else begin
      next_st.hit = lvl & ~st.gated;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hit      = st.hit;
  assign level_ok = st.level_ok;

endmodule : epi_detect

// file: hw/epi_ctrl.sv
`timescale 1ns/1ps
module epi_ctrl (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire epi_pkg::epi_bus_req_s bus_req,
  output epi_pkg::epi_bus_rsp_s      bus_rsp,
  input  wire epi_pkg::epi_cmd_s     cmd_in,
  input  wire logic                  irq_ack_a,
  input  wire logic                  irq_ack_b,
  input  wire logic                  ext_irq_pin_a,
  input  wire logic                  ext_irq_pin_b,
  input  wire logic                  port_out_a,
  input  wire logic                  port_out_b,
  output logic                       shared_port_a,
  output logic                       shared_port_b,
  output logic                       skip_taken,
  output logic                       power_down,
  output logic                       irq
);
  import epi_pkg::*;

  typedef struct packed {
    logic [3:0]  pin_a_control_reg;
    logic [3:0]  pin_b_control_reg;
    logic [3:0]  irq_enable_reg_one;
    logic        ext0_request_flag;
    logic        ext1_request_flag;
    logic        wakeup_enable_pin_a;
    logic        wakeup_enable_pin_b;
    epi_pwr_e    pwr;
    logic        ack;
    logic [31:0] rdata;
    logic        skip_taken;
    logic        port_a;
    logic        port_b;
    logic        irq;
  } epi_ctl_s;

  epi_ctl_s   st;
  epi_ctl_s   next_st;
  logic       hit_a;
  logic       hit_b;
  logic       lvl_a;
  logic       lvl_b;

  // Both pins share one detector design; the synchroniser lives inside it.
  epi_detect u_det_a (
    .mclk     (mclk),
    .reset    (reset),
    .pin      (ext_irq_pin_a),
    .ctrl     (st.pin_a_control_reg),
    .hit      (hit_a),
    .level_ok (lvl_a)
  );

  epi_detect u_det_b (
    .mclk     (mclk),
    .reset    (reset),
    .pin      (ext_irq_pin_b),
    .ctrl     (st.pin_b_control_reg),
    .hit      (hit_b),
    .level_ok (lvl_b)
  );

  // Status word as software sees it.
  function automatic logic [31:0] status_word(input epi_ctl_s s);
    logic [31:0] w;
    w = 32'h0;
    w[EPI_ST_FLAG_A]     = s.ext0_request_flag;
    w[EPI_ST_FLAG_B]     = s.ext1_request_flag;
    w[EPI_ST_POWER_DOWN] = (s.pwr == EPI_DOWN);
    w[EPI_ST_WAKE_A]     = s.wakeup_enable_pin_a;
    w[EPI_ST_WAKE_B]     = s.wakeup_enable_pin_b;
    return w;
  endfunction : status_word

  // One process holds registers, flags, the arm sequence and the bus answer.
  // Every access answers one cycle after it is seen: waitrequest is high until then.
  always_comb begin
    logic clr_a;
    logic clr_b;
    logic wr;
    clr_a = 1'b0;
    clr_b = 1'b0;
    wr    = 1'b0;
    next_st            = st;
    next_st.skip_taken = 1'b0;
    next_st.ack        = 1'b0;
    // Port drivers pass through one register stage, interrupt mode or not.
    next_st.port_a = port_out_a;
    next_st.port_b = port_out_b;

    if ((bus_req.read | bus_req.write) & ~st.ack) begin
      next_st.ack = 1'b1;
      unique case (bus_req.address)
        EPI_OFS_PIN_A_CTRL: next_st.rdata = {28'h0, st.pin_a_control_reg};
        EPI_OFS_PIN_B_CTRL: next_st.rdata = {28'h0, st.pin_b_control_reg};
        EPI_OFS_IRQ_EN_ONE: next_st.rdata = {28'h0, st.irq_enable_reg_one};
        EPI_OFS_STATUS:     next_st.rdata = status_word(st);
        default:            next_st.rdata = 32'h0;
      endcase
    end

    // A write lands only on the edge where the master sees waitrequest low.
    wr = bus_req.write & st.ack;
    if (wr) begin
      unique case (bus_req.address)
        EPI_OFS_PIN_A_CTRL: next_st.pin_a_control_reg  = bus_req.writedata[3:0];
        EPI_OFS_PIN_B_CTRL: next_st.pin_b_control_reg  = bus_req.writedata[3:0];
        EPI_OFS_IRQ_EN_ONE: next_st.irq_enable_reg_one = bus_req.writedata[3:0];
        EPI_OFS_STATUS: begin
          // Writing a one clears a flag; an edge in the same cycle still wins below.
          clr_a = bus_req.writedata[EPI_ST_FLAG_A];
          clr_b = bus_req.writedata[EPI_ST_FLAG_B];
        end
        default: ;
      endcase
    end

    // Skip-test clears only while the interrupt is disabled; acceptance also clears.
    unique case (cmd_in.cmd)
      EPI_CMD_SKIP_A: begin
        if (~st.irq_enable_reg_one[EPI_EN_EXT_A]) begin
          clr_a = 1'b1;
          next_st.skip_taken = st.ext0_request_flag;
        end
      end
      EPI_CMD_SKIP_B: begin
        if (~st.irq_enable_reg_one[EPI_EN_EXT_B]) begin
          clr_b = 1'b1;
          next_st.skip_taken = st.ext1_request_flag;
        end
      end
      EPI_CMD_WAKE_EN_A: next_st.wakeup_enable_pin_a = cmd_in.wdata;
      EPI_CMD_WAKE_EN_B: next_st.wakeup_enable_pin_b = cmd_in.wdata;
      default: ;
    endcase
    clr_a = clr_a | irq_ack_a;
    clr_b = clr_b | irq_ack_b;

    // Set wins over clear so an edge in the clearing cycle is kept.
    next_st.ext0_request_flag = hit_a | (st.ext0_request_flag & ~clr_a);
    next_st.ext1_request_flag = hit_b | (st.ext1_request_flag & ~clr_b);

    // Arm, then power-down must be the next command other than a repeated arm, which keeps the sequence armed.
    unique case (st.pwr)
      EPI_RUN: begin
        if (cmd_in.cmd == EPI_CMD_ARM) begin
          next_st.pwr = EPI_ARMED;
        end
      end
      EPI_ARMED: begin
        if (cmd_in.cmd == EPI_CMD_PD || cmd_in.cmd == EPI_CMD_PD_KEEP) begin
          next_st.pwr = EPI_DOWN;
        end else if (cmd_in.cmd != EPI_CMD_ARM) begin
          next_st.pwr = EPI_RUN;
        end
      end
      EPI_DOWN: begin
        if ((st.wakeup_enable_pin_a & lvl_a) | (st.wakeup_enable_pin_b & lvl_b)) begin
          next_st.pwr = EPI_RUN;
        end
      end
      default: next_st.pwr = EPI_RUN;
    endcase

    next_st.irq = (next_st.ext0_request_flag & next_st.irq_enable_reg_one[EPI_EN_EXT_A])
                | (next_st.ext1_request_flag & next_st.irq_enable_reg_one[EPI_EN_EXT_B]);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st                    <= '0;
      st.pin_a_control_reg  <= EPI_CTL_RESET;
      st.pin_b_control_reg  <= EPI_CTL_RESET;
      st.irq_enable_reg_one <= EPI_IRQ_EN_RESET;
      st.pwr                <= EPI_RUN;
    end else begin
      st <= next_st;
    end
  end

  assign bus_rsp.readdata    = st.rdata;
  assign bus_rsp.waitrequest = ~st.ack;
  assign shared_port_a       = st.port_a;
  assign shared_port_b       = st.port_b;
  assign skip_taken          = st.skip_taken;
  assign power_down          = st.pwr[2]; // One-hot, so the down bit is the flop itself.
  assign irq                 = st.irq;

  // Assertions.
  property p_pd_only_after_arm;
    @(posedge mclk) disable iff (reset)
      $rose(power_down) |-> $past(st.pwr) == EPI_ARMED;
  endproperty
  a_pd_only_after_arm: assert property (p_pd_only_after_arm)
    else $error("Power down entered without arming.");

  property p_lone_pd;
    @(posedge mclk) disable iff (reset)
      (st.pwr == EPI_RUN && cmd_in.cmd == EPI_CMD_PD) |=> !power_down;
  endproperty
  a_lone_pd: assert property (p_lone_pd)
    else $error("Lone power-down command entered power down.");

  property p_flag_sticky_a;
    @(posedge mclk) disable iff (reset)
      (st.ext0_request_flag && !irq_ack_a && cmd_in.cmd != EPI_CMD_SKIP_A
       && !(bus_req.write && st.ack && bus_req.address == EPI_OFS_STATUS))
       |=> st.ext0_request_flag;
  endproperty
  a_flag_sticky_a: assert property (p_flag_sticky_a)
    else $error("Flag A dropped without a clear.");

  property p_hit_sets_b;
    @(posedge mclk) disable iff (reset)
      hit_b |=> st.ext1_request_flag;
  endproperty
  a_hit_sets_b: assert property (p_hit_sets_b)
    else $error("Flag B not set on a detected edge.");

  property p_disabled_quiet;
    @(posedge mclk) disable iff (reset)
      (!st.pin_a_control_reg[EPI_CTL_INPUT_EN])[*3] |=> !hit_a;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("Disabled pin A produced an edge.");

  property p_skip_masked;
    @(posedge mclk) disable iff (reset)
      (cmd_in.cmd == EPI_CMD_SKIP_A && st.irq_enable_reg_one[EPI_EN_EXT_A]
       && st.ext0_request_flag && !irq_ack_a) |=> st.ext0_request_flag && !skip_taken;
  endproperty
  a_skip_masked: assert property (p_skip_masked)
    else $error("Skip-test acted while interrupt enabled.");

  property p_port_pass;
    @(posedge mclk) disable iff (reset)
      1'b1 |=> shared_port_a == $past(port_out_a) && shared_port_b == $past(port_out_b);
  endproperty
  a_port_pass: assert property (p_port_pass)
    else $error("Shared port output not driven.");

  property p_bus_answer;
    @(posedge mclk) disable iff (reset)
      (bus_req.read || bus_req.write) |-> ##[0:1] !bus_rsp.waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("Bus access not answered in one cycle.");

  property p_both_edges;
    @(posedge mclk) disable iff (reset)
      ($past(st.pin_b_control_reg[EPI_CTL_BOTH]) && $fell(lvl_b)) |-> hit_b;
  endproperty
  a_both_edges: assert property (p_both_edges)
    else $error("Falling edge missed in both-edge mode.");

  c_power_down: cover property (@(posedge mclk) disable iff (reset) $rose(power_down));
  c_flag_a:     cover property (@(posedge mclk) disable iff (reset) $rose(st.ext0_request_flag));
  c_skip:       cover property (@(posedge mclk) disable iff (reset) skip_taken);
  c_irq:        cover property (@(posedge mclk) disable iff (reset) irq);

endmodule : epi_ctrl

// file: bench/epi_pin_model.sv
`timescale 1ns/1ps
// External sources on both pins; in slow mode a pin settles only after a random lag.
module epi_pin_model (
  input  wire logic mclk,
  input  wire logic want_a,
  input  wire logic want_b,
  input  wire logic slow,
  output logic      pin_a,
  output logic      pin_b
);
  int lag = 0;
  // Pins move on the falling edge, so the synchroniser never races the bench.
  always @(negedge mclk) begin
    if (lag > 0) begin
      lag <= lag - 1;
    end else begin
      pin_a <= want_a;
      pin_b <= want_b;
      lag   <= slow ? int'($urandom_range(4, 1)) : 0;
    end
  end
endmodule : epi_pin_model

// file: bench/epi_ctrl_tb.sv
`timescale 1ns/1ps
module epi_ctrl_tb;
  import epi_pkg::*;
  logic         mclk = 1'b0;
  logic         reset = 1'b1;
  epi_bus_req_s bus_req = '0;
  epi_bus_rsp_s bus_rsp;
  epi_cmd_s     cmd_in = '0;
  logic         irq_ack_a = 1'b0;
  logic         irq_ack_b = 1'b0;
  logic         port_out_a = 1'b0;
  logic         port_out_b = 1'b0;
  logic         pin_a, pin_b, shared_port_a, shared_port_b, skip_taken, power_down, irq;
  logic         want_a = 1'b0;
  logic         want_b = 1'b0;
  logic         slow = 1'b0;
  logic [31:0]  exp_q[$];
  int           fails = 0;
  int           samples_checked = 0;
  int           skips = 0;
  int           s;

  always #25 mclk = ~mclk;

  epi_ctrl i_epi_ctrl (.mclk(mclk), .reset(reset), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .cmd_in(cmd_in), .irq_ack_a(irq_ack_a), .irq_ack_b(irq_ack_b), .ext_irq_pin_a(pin_a),
    .ext_irq_pin_b(pin_b), .port_out_a(port_out_a), .port_out_b(port_out_b),
    .shared_port_a(shared_port_a), .shared_port_b(shared_port_b), .skip_taken(skip_taken),
    .power_down(power_down), .irq(irq));

  epi_pin_model i_epi_pin_model (.mclk(mclk), .want_a(want_a), .want_b(want_b), .slow(slow),
    .pin_a(pin_a), .pin_b(pin_b));

  // Count skip pulses so a one-cycle pulse is never missed by a late look.
  always @(posedge mclk) begin
    if (skip_taken === 1'b1) begin
      skips <= skips + 1;
    end
  end

  // Read answers are matched against the oldest expectation noted by the driver.
  always @(posedge mclk) begin
    if (bus_req.read && bus_rsp.waitrequest === 1'b0 && exp_q.size() > 0) begin
      samples_checked++;
      if (bus_rsp.readdata !== exp_q[0]) begin
        fails++;
        $display("mismatch at %0t: read got %h expected %h", $time, bus_rsp.readdata, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end

  task automatic conclude();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic got, input logic exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  // One Avalon transfer: hold everything until waitrequest is sampled low.
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    bus_req <= '{read: rd, write: !rd, address: a, writedata: d};
    do begin
      @(posedge mclk);
      n++;
    end while (bus_rsp.waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      chk(1'b0, 1'b1, "bus answer timed out");
    end
    bus_req <= '0;
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b1, a, 32'h0);
  endtask : rd

  task automatic cmd(input logic [2:0] c, input logic w);
    @(posedge mclk);
    cmd_in <= '{cmd: c, wdata: w};
  endtask : cmd

  task automatic idle(input int n);
    cmd(EPI_CMD_NONE, 1'b0);
    repeat (n) @(posedge mclk);
  endtask : idle

  // Skip-test, then three no-operation cycles behind it.
  task automatic skip(input logic [2:0] c);
    cmd(c, 1'b0);
    idle(3);
  endtask : skip

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    void'($urandom(85));
    for (int i = 0; i < 4; i++) rd(4'(i * 4), 32'h0);
    rd(4'h2, 32'h0);
    want_a <= 1'b1;
    bus(1'b0, EPI_OFS_IRQ_EN_ONE, 32'h0);
    bus(1'b0, EPI_OFS_PIN_A_CTRL, 32'h8);
    idle(1);
    skip(EPI_CMD_SKIP_A);
    rd(EPI_OFS_PIN_A_CTRL, 32'h8);
    // Port outputs keep working while pin A serves as an interrupt input.
    repeat (6) begin
      @(posedge mclk);
      port_out_a <= 1'($urandom);
      port_out_b <= 1'($urandom);
      repeat (2) @(posedge mclk);
      chk(shared_port_a, port_out_a, "port a");
      chk(shared_port_b, port_out_b, "port b");
    end
    slow <= 1'b1;
    want_a <= 1'b0;
    idle(16);
    rd(EPI_OFS_STATUS, 32'h1);
    idle(10);
    rd(EPI_OFS_STATUS, 32'h1);
    s = skips;
    skip(EPI_CMD_SKIP_A);
    chk(skips == s + 1, 1'b1, "skip pulse a");
    rd(EPI_OFS_STATUS, 32'h0);
    bus(1'b0, EPI_OFS_PIN_A_CTRL, 32'h0);
    idle(1);
    skip(EPI_CMD_SKIP_A);
    want_a <= 1'b1;
    idle(8);
    want_a <= 1'b0;
    idle(12);
    rd(EPI_OFS_STATUS, 32'h0);
    want_a <= 1'b1;
    bus(1'b0, EPI_OFS_PIN_A_CTRL, 32'h8);
    idle(8);
    skip(EPI_CMD_SKIP_A);
    bus(1'b0, EPI_OFS_IRQ_EN_ONE, 32'h1);
    want_a <= 1'b0;
    idle(16);
    chk(irq, 1'b1, "irq on enabled flag");
    s = skips;
    skip(EPI_CMD_SKIP_A);
    chk(skips == s, 1'b1, "skip ignored when enabled");
    @(posedge mclk) irq_ack_a <= 1'b1;
    @(posedge mclk) irq_ack_a <= 1'b0;
    idle(3);
    chk(irq, 1'b0, "irq after ack");
    rd(EPI_OFS_STATUS, 32'h0);
    bus(1'b0, EPI_OFS_IRQ_EN_ONE, 32'h0);
    bus(1'b0, EPI_OFS_PIN_B_CTRL, 32'hE);
    idle(8);
    skip(EPI_CMD_SKIP_B);
    for (int i = 0; i < 2; i++) begin
      want_b <= !want_b;
      idle(16);
      rd(EPI_OFS_STATUS, 32'h2);
      skip(EPI_CMD_SKIP_B);
      rd(EPI_OFS_STATUS, 32'h0);
    end
    // A status write with a one in the flag's place clears it as well.
    want_b <= 1'b1;
    idle(16);
    rd(EPI_OFS_STATUS, 32'h2);
    bus(1'b0, EPI_OFS_STATUS, 32'h2);
    rd(EPI_OFS_STATUS, 32'h0);
    cmd(EPI_CMD_WAKE_EN_A, 1'b0);
    cmd(EPI_CMD_WAKE_EN_B, 1'b0);
    cmd(EPI_CMD_PD, 1'b0);
    idle(3);
    chk(power_down, 1'b0, "lone power-down");
    cmd(EPI_CMD_ARM, 1'b0);
    cmd(EPI_CMD_NONE, 1'b0);
    cmd(EPI_CMD_PD_KEEP, 1'b0);
    idle(3);
    chk(power_down, 1'b0, "gap after arm");
    cmd(EPI_CMD_ARM, 1'b0);
    cmd(EPI_CMD_PD_KEEP, 1'b0);
    idle(3);
    chk(power_down, 1'b1, "armed power-down");
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    chk(power_down, 1'b0, "power-down after reset");
    rd(EPI_OFS_PIN_B_CTRL, 32'h0);
    idle(2);
    conclude();
  end
endmodule : epi_ctrl_tb
